/* common/ivmd_defines.vh */
/*
 interrupt vector resolver and address decoder constants.
 assumes inclusion by bare name from hdl/ivmd_top.v.
*/
// Overview of operation
// - vectors and start address in FF80h-FFFFh
// - each vector is one 16-bit handler word
// - all reset causes use FFFEh, priority 63
// - system nmi sources use FFFCh, priority 62
// - user nmi sources use FFFAh, priority 61
// - watchdog interval flag uses FFF2h, priority 57
// - serial sources share FFF0h, priority 56
// - synchronous serial mode: only receive, transmit
// - port1 bits 0-3 share FFECh, priority 54
// - port2 bits 0,1,6,7 share FFEAh, priority 53
// - program memory F100h-FFFFh, vectors on top
// - boot rom 1000h-13FFh ignores writes
// - write protect bit blocks program memory writes
`ifndef IVMD_DEFINES_VH
`define IVMD_DEFINES_VH
`define IVMD_VEC_RESET   16'hFFFE
`define IVMD_VEC_SNMI    16'hFFFC
`define IVMD_VEC_UNMI    16'hFFFA
`define IVMD_VEC_TMR0    16'hFFF8
`define IVMD_VEC_TMR1    16'hFFF6
`define IVMD_VEC_RTC     16'hFFF4
`define IVMD_VEC_WDT     16'hFFF2
`define IVMD_VEC_SER     16'hFFF0
`define IVMD_VEC_ADC     16'hFFEE
`define IVMD_VEC_P1      16'hFFEC
`define IVMD_VEC_P2      16'hFFEA
`define IVMD_VEC_CMP     16'hFFE8
`define IVMD_PRI_RESET   6'h3F
`define IVMD_PRI_SNMI    6'h3E
`define IVMD_PRI_UNMI    6'h3D
`define IVMD_PRI_TMR0    6'h3C
`define IVMD_PRI_TMR1    6'h3B
`define IVMD_PRI_RTC     6'h3A
`define IVMD_PRI_WDT     6'h39
`define IVMD_PRI_SER     6'h38
`define IVMD_PRI_ADC     6'h37
`define IVMD_PRI_P1      6'h36
`define IVMD_PRI_P2      6'h35
`define IVMD_PRI_CMP     6'h34
`define IVMD_VEC_AREA_LO 16'hFF80
`define IVMD_PROG_LO     16'hF100
`define IVMD_RAM_LO      16'h2000
`define IVMD_RAM_HI      16'h23FF
`define IVMD_BOOT_LO     16'h1000
`define IVMD_BOOT_HI     16'h13FF
`define IVMD_PERI_HI     16'h0FFF
`define IVMD_RGN_NONE    3'h0
`define IVMD_RGN_PERI    3'h1
`define IVMD_RGN_BOOT    3'h2
`define IVMD_RGN_RAM     3'h3
`define IVMD_RGN_PROG    3'h4
`define IVMD_RGN_VECT    3'h5
`define IVMD_P1_MASK     8'h0F
`define IVMD_P2_MASK     8'hC3
`define IVMD_SER_SYNC_MASK 4'h3
`endif

/* hdl/ivmd_top.v */
/*
 interrupt vector resolver and memory region decoder.
 holds a fixed priority chain over the reset, nmi and maskable
 source terms, and an address decoder that grants or drops
 reads and writes per memory region; all outputs registered.
 assumes flags stay high until cleared at their source; this
 block only ranks what is pending and never clears a flag.
 assumes source flags are synchronous to clk_i; the cpu samples
 vector and decode outputs one cycle after its inputs.
*/
`timescale 1ns/1ps
`include "ivmd_defines.vh"
module ivmd_top (
  input  wire        clk_i,            // system clock
  input  wire        reset_i,          // async reset, high
  input  wire [7:0]  reset_cause_i,    // reset cause flags
  input  wire        vacant_access_flag_i,        // vacant access
  input  wire        debug_mailbox_in_flag_i,     // mailbox in
  input  wire        debug_mailbox_out_flag_i,    // mailbox out
  input  wire        access_time_error_flag_i,    // access time err
  input  wire        correctable_bit_error_flag_i,   // ecc fixed
  input  wire        uncorrectable_bit_error_flag_i, // ecc fatal
  input  wire        external_nmi_flag_i,      // nmi pin event
  input  wire        oscillator_fault_flag_i,  // oscillator fault
  input  wire        global_int_enable_i,      // gie
  input  wire        timer_cc0_flag_i,         // timer cc0
  input  wire        timer_other_flag_i,       // timer cc1/cc2/ovf
  input  wire        rtc_flag_i,               // rtc counter
  input  wire        watchdog_flag_i,          // interval mode
  input  wire        serial_sync_mode_i,       // 1: synchronous mode
  input  wire        serial_tx_complete_flag_i, // tx complete
  input  wire        serial_start_bit_flag_i,  // start bit
  input  wire        serial_receive_flag_i,    // receive
  input  wire        serial_transmit_flag_i,   // transmit
  input  wire        adc_flag_i,               // adc any
  input  wire [7:0]  port1_edge_flags_i,       // port1 edges
  input  wire [7:0]  port2_edge_flags_i,       // port2 edges
  input  wire        comparator_flag_i,        // comparator any
  input  wire [15:0] addr_i,                   // access address
  input  wire        wr_i,                     // write request
  input  wire        rd_i,                     // read request
  input  wire        program_write_protect_bit_i, // config reg0 bit
  output reg         int_req_o,                // request pending
  output reg  [15:0] vector_addr_o,            // vector word address
  output reg  [5:0]  vector_pri_o,             // winning priority
  output reg         vector_nmi_o,             // winner non-maskable
  output reg  [2:0]  region_o,                 // decoded region
  output reg         wr_en_o,                  // write allowed
  output reg         rd_en_o,                  // read allowed
  output reg         wr_blocked_o              // write dropped
);

  // per-source request terms
  wire        req_reset;     // any reset cause
  wire        req_snmi;      // system nmi
  wire        req_unmi;      // user nmi
  wire        req_ser;       // serial shared vector
  wire        req_p1;        // port1 shared vector
  wire        req_p2;        // port2 shared vector
  wire        mask_ok;       // maskable sources allowed

  // next-state values for the output flops
  reg         req_nxt;       // next request
  reg  [15:0] vec_nxt;       // next vector address
  reg  [5:0]  pri_nxt;       // next priority
  reg         nmi_nxt;       // next non-maskable marker
  reg  [2:0]  rgn_nxt;       // next region
  reg         wen_nxt;       // next write enable
  reg         ren_nxt;       // next read enable
  reg         blk_nxt;       // next blocked marker

  // any reset cause selects the top vector
  assign req_reset = |reset_cause_i;
  // nmi terms are never gated by gie
  assign req_snmi  = vacant_access_flag_i | debug_mailbox_in_flag_i |
                     debug_mailbox_out_flag_i | access_time_error_flag_i |
                     correctable_bit_error_flag_i |
                     uncorrectable_bit_error_flag_i;
  assign req_unmi  = external_nmi_flag_i | oscillator_fault_flag_i;
  // sync mode drops tx-complete and start-bit sources
  assign req_ser   = serial_receive_flag_i | serial_transmit_flag_i |
                     (~serial_sync_mode_i &
                      (serial_tx_complete_flag_i |
                       serial_start_bit_flag_i));
  // masks keep only the pins that own an edge flag
  assign req_p1    = |(port1_edge_flags_i & `IVMD_P1_MASK);
  assign req_p2    = |(port2_edge_flags_i & `IVMD_P2_MASK);
  // gie gates the maskable sources only
  assign mask_ok   = global_int_enable_i;

  // fixed priority chain, highest first; reserved slots absent
  always @* begin
    // defaults: reset vector shown, request high
    req_nxt = 1'b1;
    nmi_nxt = 1'b1;
    vec_nxt = `IVMD_VEC_RESET;
    pri_nxt = `IVMD_PRI_RESET;
    if (req_reset) begin
      // reset wins over every other source
      vec_nxt = `IVMD_VEC_RESET;
      pri_nxt = `IVMD_PRI_RESET;
    end else if (req_snmi) begin
      // system nmi, ignores gie
      vec_nxt = `IVMD_VEC_SNMI;
      pri_nxt = `IVMD_PRI_SNMI;
    end else if (req_unmi) begin
      // user nmi, ignores gie
      vec_nxt = `IVMD_VEC_UNMI;
      pri_nxt = `IVMD_PRI_UNMI;
    end else begin
      nmi_nxt = 1'b0;
      if (mask_ok && timer_cc0_flag_i) begin
        // timer channel 0, priority 60
        vec_nxt = `IVMD_VEC_TMR0;
        pri_nxt = `IVMD_PRI_TMR0;
      end else if (mask_ok && timer_other_flag_i) begin
        // other timer channels and overflow, priority 59
        vec_nxt = `IVMD_VEC_TMR1;
        pri_nxt = `IVMD_PRI_TMR1;
      end else if (mask_ok && rtc_flag_i) begin
        // rtc counter, priority 58
        vec_nxt = `IVMD_VEC_RTC;
        pri_nxt = `IVMD_PRI_RTC;
      end else if (mask_ok && watchdog_flag_i) begin
        // watchdog interval flag, not its reset cause
        vec_nxt = `IVMD_VEC_WDT;
        pri_nxt = `IVMD_PRI_WDT;
      end else if (mask_ok && req_ser) begin
        // serial shared vector
        vec_nxt = `IVMD_VEC_SER;
        pri_nxt = `IVMD_PRI_SER;
      end else if (mask_ok && adc_flag_i) begin
        // adc shared vector, priority 55
        vec_nxt = `IVMD_VEC_ADC;
        pri_nxt = `IVMD_PRI_ADC;
      end else if (mask_ok && req_p1) begin
        // port1 pins 0 to 3
        vec_nxt = `IVMD_VEC_P1;
        pri_nxt = `IVMD_PRI_P1;
      end else if (mask_ok && req_p2) begin
        // port2 pins 0, 1, 6 and 7
        vec_nxt = `IVMD_VEC_P2;
        pri_nxt = `IVMD_PRI_P2;
      end else if (mask_ok && comparator_flag_i) begin
        // comparator, lowest ranked source
        vec_nxt = `IVMD_VEC_CMP;
        pri_nxt = `IVMD_PRI_CMP;
      end else begin
        // idle shows reset vector, request low
        req_nxt = 1'b0;
        nmi_nxt = 1'b0;
      end
    end
  end

  // address decode, if/else chain by region
  always @* begin
    // defaults: no region, nothing granted
    rgn_nxt = `IVMD_RGN_NONE;
    wen_nxt = 1'b0;
    ren_nxt = 1'b0;
    blk_nxt = 1'b0;
    if (addr_i >= `IVMD_VEC_AREA_LO) begin
      // vectors and signatures, protected like code
      rgn_nxt = `IVMD_RGN_VECT;
      ren_nxt = rd_i;
      wen_nxt = wr_i & ~program_write_protect_bit_i;
      blk_nxt = wr_i & program_write_protect_bit_i;
    end else if (addr_i >= `IVMD_PROG_LO) begin
      // program code below the vector area
      rgn_nxt = `IVMD_RGN_PROG;
      ren_nxt = rd_i;
      wen_nxt = wr_i & ~program_write_protect_bit_i;
      blk_nxt = wr_i & program_write_protect_bit_i;
    end else if (addr_i >= `IVMD_RAM_LO && addr_i <= `IVMD_RAM_HI) begin
      // ram, always writable
      rgn_nxt = `IVMD_RGN_RAM;
      ren_nxt = rd_i;
      wen_nxt = wr_i;
    end else if (addr_i >= `IVMD_BOOT_LO &&
                 addr_i <= `IVMD_BOOT_HI) begin
      // boot rom: reads only, writes dropped
      rgn_nxt = `IVMD_RGN_BOOT;
      ren_nxt = rd_i;
      blk_nxt = wr_i;
    end else if (addr_i <= `IVMD_PERI_HI) begin
      // peripheral space, read and write
      rgn_nxt = `IVMD_RGN_PERI;
      ren_nxt = rd_i;
      wen_nxt = wr_i;
    end else begin
      // vacant space: no access granted
      rgn_nxt = `IVMD_RGN_NONE;
    end
  end

  // output registers
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      // idle vector, nothing granted
      int_req_o     <= 1'b0;
      vector_addr_o <= `IVMD_VEC_RESET;
      vector_pri_o  <= `IVMD_PRI_RESET;
      vector_nmi_o  <= 1'b0;
      region_o      <= `IVMD_RGN_NONE;
      wr_en_o       <= 1'b0;
      rd_en_o       <= 1'b0;
      wr_blocked_o  <= 1'b0;
    end else begin
      // load the next-state terms every cycle
      int_req_o     <= req_nxt;
      vector_addr_o <= vec_nxt;
      vector_pri_o  <= pri_nxt;
      vector_nmi_o  <= nmi_nxt;
      region_o      <= rgn_nxt;
      wr_en_o       <= wen_nxt;
      rd_en_o       <= ren_nxt;
      wr_blocked_o  <= blk_nxt;
    end
  end

endmodule // ivmd_top

/* sim/ivmd_asserts.sv */
/* checker: vector and decode relations at the top ports.
 assumes binding into ivmd_top, one clock, outputs one cycle late. */
`timescale 1ns/1ps
module ivmd_asserts (
  input wire        clk_i, reset_i, rd_i, wr_i, global_int_enable_i,
  input wire        program_write_protect_bit_i, int_req_o, vector_nmi_o,
  input wire        wr_en_o, rd_en_o, wr_blocked_o,
  input wire [7:0]  reset_cause_i,
  input wire [15:0] addr_i, vector_addr_o,
  input wire [5:0]  vector_pri_o,
  input wire [2:0]  region_o
);
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // access into protected program space
  wire pa = program_write_protect_bit_i && addr_i >= 16'hF100;
  // boot write request, then the dropped write it must give
  sequence s_boot_wr; wr_i && addr_i >= 16'h1000 && addr_i <= 16'h13FF;
  endsequence
  sequence s_drop; wr_blocked_o && !wr_en_o; endsequence
  a_boot_wr: assert property (s_boot_wr |=> s_drop)
    else $error("boot write kept");
  a_prot_wr: assert property (wr_i && pa |=> s_drop)
    else $error("protected write kept");
  a_prot_rd: assert property (rd_i && pa |=> rd_en_o)
    else $error("protected read lost");
  a_vec_area: assert property (addr_i >= 16'hFF80
    |=> region_o == 3'h5) else $error("vector area missed");
  a_reset_win: assert property (|reset_cause_i |=> int_req_o
    && vector_addr_o == 16'hFFFE) else $error("reset lost");
  a_gie_gate: assert property (!global_int_enable_i
    |=> !int_req_o || vector_nmi_o) else $error("masked source won");
  a_vec_legal: assert property (int_req_o |-> !vector_addr_o[0]
    && vector_addr_o >= 16'hFFE8) else $error("vector illegal");
  a_pri_map: assert property (int_req_o |->
    vector_pri_o == {1'b1, vector_addr_o[5:1]}) else $error("bad rank");
endmodule // ivmd_asserts
bind ivmd_top ivmd_asserts u_chk (.clk_i(clk_i), .reset_i(reset_i),
  .rd_i(rd_i), .wr_i(wr_i), .global_int_enable_i(global_int_enable_i),
  .program_write_protect_bit_i(program_write_protect_bit_i),
  .int_req_o(int_req_o), .vector_nmi_o(vector_nmi_o), .wr_en_o(wr_en_o),
  .rd_en_o(rd_en_o), .wr_blocked_o(wr_blocked_o),
  .reset_cause_i(reset_cause_i), .addr_i(addr_i),
  .vector_addr_o(vector_addr_o), .vector_pri_o(vector_pri_o),
  .region_o(region_o));

/* sim/ivmd_cpu_model.sv */
/* cpu core model: issues one-cycle memory accesses.
 assumes the bench calls xfer and idle; drives at falling edges. */
`timescale 1ns/1ps
module ivmd_cpu_model (
  input  wire        clk_i,  // system clock
  output reg  [15:0] addr_o, // access address
  output reg         wr_o,   // write strobe
  output reg         rd_o    // read strobe
);
  initial {addr_o, wr_o, rd_o} = 18'h0;
  // one access held for a full cycle, outputs settled on return
  task xfer(input [15:0] a, input w, input r);
    @(negedge clk_i);
    {addr_o, wr_o, rd_o} = {a, w, r};
    @(negedge clk_i);
  endtask
  // bus released: strobes low, address shows its inverse
  task idle;
    @(negedge clk_i);
    {addr_o, wr_o, rd_o} = {~addr_o, 2'b00};
  endtask
endmodule // ivmd_cpu_model

/* sim/tb.sv */
/* tb: source flags and cpu accesses against expected results.
 assumes ivmd_top and ivmd_cpu_model; 8 ns clock. */
`timescale 1ns/1ps
module tb;
  // rank per source bit (63 minus priority), F: bit has no vector
  localparam [167:0] RK = 168'hBAAFFFFAAFFFF99998777765432211111100000000;
  reg         clk_i = 1'b0, reset_i = 1'b1, gie, sync, pwp;
  reg  [41:0] src;  // all source flags
  reg  [15:0] ex;   // expected winner, 0 when idle
  reg  [3:0]  r;    // rank of current bit
  wire [15:0] addr, vec;
  wire [5:0]  pri;
  wire [2:0]  rg;
  wire        wr, rd, req, nmi, wen, ren, blk;
  integer     n_mismatch = 0, checked = 0, cyc = 0, i, m;
  always #4 clk_i = ~clk_i;
  ivmd_cpu_model cpu (.clk_i(clk_i), .addr_o(addr), .wr_o(wr), .rd_o(rd));
  ivmd_top DUT (.clk_i(clk_i), .reset_i(reset_i), .reset_cause_i(src[7:0]),
    .vacant_access_flag_i(src[8]), .debug_mailbox_in_flag_i(src[9]),
    .debug_mailbox_out_flag_i(src[10]), .access_time_error_flag_i(src[11]),
    .correctable_bit_error_flag_i(src[12]), .timer_cc0_flag_i(src[16]),
    .uncorrectable_bit_error_flag_i(src[13]), .rtc_flag_i(src[18]),
    .external_nmi_flag_i(src[14]), .oscillator_fault_flag_i(src[15]),
    .global_int_enable_i(gie), .timer_other_flag_i(src[17]),
    .watchdog_flag_i(src[19]), .serial_sync_mode_i(sync),
    .serial_tx_complete_flag_i(src[20]), .serial_start_bit_flag_i(src[21]),
    .serial_receive_flag_i(src[22]), .serial_transmit_flag_i(src[23]),
    .adc_flag_i(src[24]), .port1_edge_flags_i(src[32:25]),
    .port2_edge_flags_i(src[40:33]), .comparator_flag_i(src[41]),
    .addr_i(addr), .wr_i(wr), .rd_i(rd), .program_write_protect_bit_i(pwp),
    .int_req_o(req), .vector_addr_o(vec), .vector_pri_o(pri), .rd_en_o(ren),
    .vector_nmi_o(nmi), .region_o(rg), .wr_en_o(wen), .wr_blocked_o(blk));
  // cut a hang short
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      bad("timeout");
      end_of_test;
    end
  end
  task bad(input string s);
    n_mismatch++;
    $display("Error %0t: %s mismatch", $time, s);
  endtask
  task end_of_test;
    if (n_mismatch == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // vector outputs against ex, idle shows FFFE priority 63
  task chk;
    reg [15:0] x;
    x = (ex != 16'h0) ? ex : 16'hFFFE;
    checked++;
    if ({req, vec, pri, nmi} !== {ex != 0, x, 1'b1, x[5:1], ex > 16'hFFF9})
      bad("vector");
  endtask
  // one access; wrp: write, read, protect; e: region, wen, ren, blocked
  task acc(input [15:0] a, input [2:0] wrp, input [5:0] e);
    pwp = wrp[0];
    cpu.xfer(a, wrp[2], wrp[1]);
    checked++;
    if ({rg, wen, ren, blk} !== e) bad("access");
  endtask
  initial begin
    {src, gie, sync, pwp, ex} = 61'h0;
    repeat (4) @(negedge clk_i);
    reset_i = 1'b0;
    @(negedge clk_i);
    chk;
    // each source alone, under every gie and serial mode
    for (m = 0; m < 4; m = m + 1)
      for (i = 0; i < 42; i = i + 1) begin
        {src, sync, gie} = {42'h1 << i, m[1:0]};
        r = RK[4*i +: 4];
        ex = (r == 4'hF) ? 16'h0 : 16'hFFFE - {r, 1'b0};
        if ((!gie && i > 15) || (sync && (i == 20 || i == 21))) ex = 16'h0;
        @(negedge clk_i);
        chk;
      end
    // raise sources from highest rank (11) down to rank 0: the newest with a vector must win
    {src, gie, sync, ex} = {42'h0, 2'b10, 16'h0};
    @(negedge clk_i);
    for (i = 41; i >= 0; i = i - 1) begin
      src[i] = 1'b1;
      r = RK[4*i +: 4];
      if (r != 4'hF) ex = 16'hFFFE - {r, 1'b0};
      @(negedge clk_i);
      chk;
    end
    src = 42'h0;
    acc(16'h0FFF, 3'h2, 6'h0A);
    acc(16'h1000, 3'h4, 6'h11);
    acc(16'h13FF, 3'h2, 6'h12);
    acc(16'h1400, 3'h2, 6'h00);
    acc(16'h2000, 3'h4, 6'h1C);
    acc(16'h23FF, 3'h2, 6'h1A);
    acc(16'hF0FF, 3'h4, 6'h00);
    acc(16'hF100, 3'h5, 6'h21);
    acc(16'hFF7F, 3'h3, 6'h22);
    acc(16'hFF80, 3'h5, 6'h29);
    acc(16'hFFFF, 3'h4, 6'h2C);
    cpu.idle;
    end_of_test;
  end
endmodule // tb
